// file: common/dpsem_pkg.sv
// package for the semaphore port controller
`default_nettype none
package dpsem_pkg;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int DATA_W = 18;
  localparam int IDX_W = 3;
  localparam int FLAG_COUNT = 8;
  localparam int CYC_W = 4;
  // ****************************************
  // pin timing in clock cycles (100 ns each)
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int PULSE_NS = 200;
  localparam int GAP_NS = 100;
  localparam logic [CYC_W-1:0] SETUP_CYC = CYC_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] PULSE_CYC = CYC_W'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] GAP_CYC = CYC_W'((GAP_NS + CLK_NS - 1) / CLK_NS);
  // read data passes two flip-flops before capture
  localparam logic [CYC_W-1:0] SYNC_CYC = CYC_W'(2);
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] OWN_OFS = 4'h8;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 4;
  localparam int CMD_ALL_BIT = 8;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OWN_BIT = 1;
  localparam int ST_DATA_LSB = 8;
  // ****************************************
  // command codes
  // ****************************************
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_ACQUIRE = 2'h1,
    OP_RELEASE = 2'h2,
    OP_POLL = 2'h3
  } dpsem_op_t;
  // pin side signals toward the device port
  typedef struct packed {
    logic semaphore_select_n;
    logic chip_enable_n;
    logic rw_n;
    logic output_enable_n;
    logic [IDX_W-1:0] flag_index_lines;
    logic [DATA_W-1:0] data;
    logic data_oe;
  } dpsem_pins_t;
  // one pin cycle order
  typedef struct packed {
    logic write;
    logic bit0;
    logic [IDX_W-1:0] index;
  } dpsem_acc_t;
endpackage : dpsem_pkg
`default_nettype wire

// file: design/dpsem_cycle.sv
// one semaphore pin cycle toward the device port
`timescale 1ns/100ps
`default_nettype none
module dpsem_cycle (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire dpsem_pkg::dpsem_acc_t acc_i,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_i,
  output dpsem_pkg::dpsem_pins_t pins_o,
  output logic done_o,
  output logic [dpsem_pkg::DATA_W-1:0] rdata_o
);
  // ****************************************
  // cycle sequencer
  // ****************************************
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_GAP} dpsem_cst_t;
  dpsem_cst_t st_reg;
  logic [dpsem_pkg::CYC_W-1:0] cnt_reg;
  dpsem_pkg::dpsem_acc_t acc_reg;
  logic [dpsem_pkg::DATA_W-1:0] sync1_reg;
  logic [dpsem_pkg::DATA_W-1:0] sync2_reg;
  wire cnt_done = (cnt_reg == dpsem_pkg::CYC_W'(1));
  wire active = (st_reg == C_SETUP) || (st_reg == C_PULSE);
  always_ff @(posedge clk_i) begin
    sync1_reg <= data_i;
    sync2_reg <= sync1_reg;
    done_o <= 1'b0;
    if (rst_i) begin
      st_reg <= C_IDLE;
      cnt_reg <= '0;
      acc_reg <= '0;
      rdata_o <= '0;
    end else begin
      unique case (st_reg)
        C_IDLE: begin
          if (start_i) begin
            acc_reg <= acc_i;
            cnt_reg <= dpsem_pkg::SETUP_CYC;
            st_reg <= C_SETUP;
          end
        end
        C_SETUP: begin
          cnt_reg <= cnt_reg - dpsem_pkg::CYC_W'(1);
          if (cnt_done) begin
            cnt_reg <= dpsem_pkg::PULSE_CYC + dpsem_pkg::SYNC_CYC;
            st_reg <= C_PULSE;
          end
        end
        C_PULSE: begin
          cnt_reg <= cnt_reg - dpsem_pkg::CYC_W'(1);
          if (cnt_done) begin
            rdata_o <= sync2_reg;
            cnt_reg <= dpsem_pkg::GAP_CYC;
            st_reg <= C_GAP;
          end
        end
        C_GAP: begin
          cnt_reg <= cnt_reg - dpsem_pkg::CYC_W'(1);
          if (cnt_done) begin
            done_o <= 1'b1;
            st_reg <= C_IDLE;
          end
        end
      endcase
    end
  end
  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '{semaphore_select_n: 1'b1, chip_enable_n: 1'b1, rw_n: 1'b1,
                  output_enable_n: 1'b1, flag_index_lines: '0, data: '0, data_oe: 1'b0};
    end else begin
      pins_o.semaphore_select_n <= !(active || (start_i && st_reg == C_IDLE)); // R3
      pins_o.chip_enable_n <= 1'b1; // R19
      pins_o.flag_index_lines <= (st_reg == C_IDLE) ? acc_i.index : acc_reg.index;
      pins_o.data <= {dpsem_pkg::DATA_W{(st_reg == C_IDLE) ? acc_i.bit0 : acc_reg.bit0}};
      pins_o.rw_n <= !(acc_reg.write && st_reg == C_SETUP && !cnt_done)
                     && !(acc_reg.write && st_reg == C_SETUP && cnt_done)
                     && !(acc_reg.write && st_reg == C_PULSE && !cnt_done);
      pins_o.data_oe <= acc_reg.write && (st_reg == C_SETUP || (st_reg == C_PULSE && !cnt_done));
      // output enable drops between reads so each read latches afresh
      pins_o.output_enable_n <= !(!acc_reg.write && active
                                  && !(st_reg == C_PULSE && cnt_done)); // R10
    end
  end
endmodule : dpsem_cycle
`default_nettype wire

// file: design/dpsem_ctrl.sv
// wishbone controlled semaphore client for one device port
// Behaviour
// R1: device holds eight flags, own space
// R2: write zero requests, write one releases
// R3: select low plus enable, direction accesses
// R4: only three low address lines pick flag
// R5: device takes data bit zero only
// R6: free flag taken reads zero here
// R7: owner release frees flag both sides
// R8: read spreads flag on every data bit
// R9: read value latched while select, enable
// R10: drop select or enable between reads
// R11: acquire writes zero then reads back
// R12: losing request stays pending, reads one
// R13: first request latch wins the flag
// R14: pending request takes over on release
// R15: new owner holds until it writes one
// R16: failed request: keep reading or withdraw
// R17: simultaneous requests grant exactly one
// R18: at start write one to every flag
// R19: keep chip enable high during access
// R20: both ports behave identically
`timescale 1ns/100ps
`default_nettype none
module dpsem_ctrl #(
  parameter int FLAGS = dpsem_pkg::FLAG_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // ****************************************
  // wishbone slave
  // ****************************************
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // ****************************************
  // device port pins
  // ****************************************
  output logic semaphore_select_n_o,
  output logic chip_enable_n_o,
  output logic rw_n_o,
  output logic output_enable_n_o,
  output logic [dpsem_pkg::IDX_W-1:0] flag_index_lines_o,
  output logic [dpsem_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_i
);
  // ****************************************
  // controller state
  // ****************************************
  typedef enum logic [2:0] {S_INIT, S_IDLE, S_WRITE, S_READ, S_NEXT} dpsem_st_t;
  dpsem_st_t st_reg;
  dpsem_pkg::dpsem_op_t op_reg;
  logic [dpsem_pkg::IDX_W-1:0] idx_reg;
  logic all_reg;
  logic [FLAGS-1:0] own_reg;
  logic last_own_reg;
  logic [dpsem_pkg::DATA_W-1:0] last_data_reg;
  logic start_reg;
  dpsem_pkg::dpsem_acc_t acc_reg;
  dpsem_pkg::dpsem_pins_t pins;
  logic cyc_done;
  logic [dpsem_pkg::DATA_W-1:0] cyc_rdata;
  // ****************************************
  // bus decode
  // ****************************************
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire busy = (st_reg != S_IDLE);
  wire cmd_wr = bus_req && wb_we_i && (wb_adr_i == dpsem_pkg::CMD_OFS) && wb_sel_i[0] && !busy;
  wire cmd_wr_hi = bus_req && wb_we_i && (wb_adr_i == dpsem_pkg::CMD_OFS) && wb_sel_i[1];
  wire [1:0] cmd_op = wb_dat_i[dpsem_pkg::CMD_OP_LSB +: 2];
  wire [dpsem_pkg::IDX_W-1:0] cmd_idx = wb_dat_i[dpsem_pkg::CMD_IDX_LSB +: dpsem_pkg::IDX_W];
  wire [31:0] stat_word = {6'h00, last_data_reg, 6'h00, last_own_reg, busy};
  wire [31:0] own_word = 32'(own_reg);
  wire [31:0] rd_mux = (wb_adr_i == dpsem_pkg::STAT_OFS) ? stat_word :
                       (wb_adr_i == dpsem_pkg::OWN_OFS) ? own_word : 32'h00000000;
  wire read_is_zero = (cyc_rdata[0] == 1'b0); // R8
  // ****************************************
  // bus slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_mux;
    end
  end
  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    start_reg <= 1'b0;
    if (rst_i) begin
      st_reg <= S_INIT;
      op_reg <= dpsem_pkg::OP_RELEASE;
      idx_reg <= '0;
      all_reg <= 1'b1;
      own_reg <= '0;
      last_own_reg <= 1'b0;
      last_data_reg <= '0;
      acc_reg <= '0;
    end else begin
      unique case (st_reg)
        S_INIT: begin
          // release every flag from this port after reset
          acc_reg <= '{write: 1'b1, bit0: 1'b1, index: idx_reg}; // R18
          start_reg <= 1'b1;
          st_reg <= S_WRITE;
        end
        S_IDLE: begin
          if (cmd_wr && dpsem_pkg::dpsem_op_t'(cmd_op) != dpsem_pkg::OP_NONE) begin
            op_reg <= dpsem_pkg::dpsem_op_t'(cmd_op);
            idx_reg <= cmd_idx; // R4
            all_reg <= cmd_wr_hi && wb_dat_i[dpsem_pkg::CMD_ALL_BIT];
            start_reg <= 1'b1;
            if (dpsem_pkg::dpsem_op_t'(cmd_op) == dpsem_pkg::OP_POLL) begin
              acc_reg <= '{write: 1'b0, bit0: 1'b1, index: cmd_idx};
              st_reg <= S_READ;
            end else begin
              // acquire writes zero, release writes one
              acc_reg <= '{write: 1'b1,
                           bit0: (dpsem_pkg::dpsem_op_t'(cmd_op) != dpsem_pkg::OP_ACQUIRE),
                           index: cmd_idx}; // R2
              st_reg <= S_WRITE;
            end
          end
        end
        S_WRITE: begin
          if (cyc_done) begin
            if (op_reg == dpsem_pkg::OP_ACQUIRE) begin
              // read back after the request write
              acc_reg <= '{write: 1'b0, bit0: 1'b1, index: idx_reg}; // R11
              start_reg <= 1'b1;
              st_reg <= S_READ;
            end else begin
              own_reg[idx_reg] <= 1'b0; // R7
              last_own_reg <= 1'b0;
              st_reg <= S_NEXT;
            end
          end
        end
        S_READ: begin
          if (cyc_done) begin
            // zero here means this port holds the token
            own_reg[idx_reg] <= read_is_zero; // R6 R12 R13 R14 R15
            last_own_reg <= read_is_zero;
            last_data_reg <= cyc_rdata;
            st_reg <= S_IDLE;
          end
        end
        S_NEXT: begin
          // a lost request stays pending until software polls or releases
          if (all_reg && idx_reg != dpsem_pkg::IDX_W'(FLAGS - 1)) begin // R16
            idx_reg <= idx_reg + dpsem_pkg::IDX_W'(1);
            acc_reg <= '{write: 1'b1, bit0: 1'b1, index: idx_reg + dpsem_pkg::IDX_W'(1)};
            start_reg <= 1'b1;
            st_reg <= S_WRITE;
          end else begin
            all_reg <= 1'b0;
            st_reg <= S_IDLE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // pin cycle engine
  // ****************************************
  dpsem_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_reg),
    .acc_i(acc_reg),
    .data_i(data_i),
    .pins_o(pins),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata)
  );
  assign semaphore_select_n_o = pins.semaphore_select_n; // R3
  assign chip_enable_n_o = pins.chip_enable_n; // R19
  assign rw_n_o = pins.rw_n;
  assign output_enable_n_o = pins.output_enable_n; // R9
  assign flag_index_lines_o = pins.flag_index_lines;
  assign data_o = pins.data; // R5
  assign data_oe_o = pins.data_oe;
endmodule : dpsem_ctrl
`default_nettype wire

// file: test/dpsem_ctrl_asserts.sv
// checker for the semaphore port controller
`timescale 1ns/100ps
`default_nettype none
module dpsem_ctrl_asserts #(
  parameter int FLAGS = dpsem_pkg::FLAG_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic semaphore_select_n_o,
  input wire logic chip_enable_n_o,
  input wire logic rw_n_o,
  input wire logic output_enable_n_o,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // pin and bus checks
  // ****
  a_ce_high: assert property (chip_enable_n_o)
    else $error("array enable low");
  a_read_quiet: assert property (!output_enable_n_o |->
      rw_n_o && !data_oe_o && !semaphore_select_n_o)
    else $error("read without select or with drive");
  a_write_sel: assert property (!rw_n_o |->
      !semaphore_select_n_o && data_oe_o && output_enable_n_o)
    else $error("write pulse outside select");
  a_setup_first: assert property ($fell(semaphore_select_n_o) |->
      rw_n_o && output_enable_n_o)
    else $error("no setup cycle");
  a_read_back: assert property (!rw_n_o && !data_o[0] |-> ##[1:12] !output_enable_n_o)
    else $error("request write not read back");
  a_data_copy: assert property (data_oe_o |-> data_o == {dpsem_pkg::DATA_W{data_o[0]}})
    else $error("write data not replicated");
  a_read_ends: assert property ($fell(output_enable_n_o) |-> ##[1:8] semaphore_select_n_o)
    else $error("select held after read");
  a_init_free: assert property ($fell(rst_i) |-> ##[1:30] (!rw_n_o && data_o[0]))
    else $error("no release write after reset");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  c_write: cover property (!rw_n_o && !data_o[0]);
  c_read: cover property ($fell(output_enable_n_o));
  c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule : dpsem_ctrl_asserts
bind dpsem_ctrl dpsem_ctrl_asserts #(.FLAGS(FLAGS)) i_dpsem_ctrl_asserts (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .semaphore_select_n_o, .chip_enable_n_o,
  .rw_n_o, .output_enable_n_o, .data_o, .data_oe_o);
`default_nettype wire

// file: test/dpsem_dev_model.sv
// behavioural two-port semaphore device, port 0 and port 1
`timescale 1ns/100ps
`default_nettype none
module dpsem_dev_model (
  input wire logic clk_i,
  input wire logic [1:0] sel_n_i,
  input wire logic [1:0] rw_n_i,
  input wire logic [1:0] oe_n_i,
  input wire logic [1:0][2:0] idx_i,
  input wire logic [1:0][17:0] d_i,
  output logic [1:0][17:0] q_o
);
  // power-up junk: port 0 owns all, port 1 pending on all
  logic [1:0][7:0] rq = '1;
  logic [1:0][7:0] own = 16'h00FF;
  logic [1:0] lat = 2'h0;
  logic [1:0] rd = 2'h0;
  task automatic wr(input int p, input int i, input logic b);
    rq[p][i] = !b;
    if (!b && !own[1-p][i]) own[p][i] = 1'b1;
    if (b && own[p][i]) begin
      own[p][i] = 1'b0;
      own[1-p][i] = rq[1-p][i];
    end
  endtask : wr
  always @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (!sel_n_i[p] && !rw_n_i[p]) wr(p, idx_i[p], d_i[p][0]);
      if (!sel_n_i[p] && !oe_n_i[p] && !rd[p]) lat[p] <= !own[p][idx_i[p]];
      rd[p] <= !sel_n_i[p] && !oe_n_i[p];
    end
  end
  // idle bus shows the inverse of the last value
  assign q_o[0] = rd[0] ? {18{lat[0]}} : ~{18{lat[0]}};
  assign q_o[1] = rd[1] ? {18{lat[1]}} : ~{18{lat[1]}};
endmodule : dpsem_dev_model
`default_nettype wire

// file: test/tb_top.sv
// testbench for the semaphore port controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, dato, rdat, v;
  logic ack, c_sel, c_rw, c_oe, c_doe, ce_n;
  logic r_sel_n = 1'h1, r_rw_n = 1'h1, r_oe_n = 1'h1, r_d0 = 1'h1;
  logic [2:0] r_idx = 3'h0, c_idx;
  logic [17:0] c_d;
  logic [1:0][17:0] q;
  int bad_count = 0, n_compared = 0, cycles = 0;
  always #50 clk_i = ~clk_i;
  dpsem_ctrl i_dpsem_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .semaphore_select_n_o(c_sel), .chip_enable_n_o(ce_n), .rw_n_o(c_rw),
    .output_enable_n_o(c_oe), .flag_index_lines_o(c_idx), .data_o(c_d), .data_oe_o(c_doe),
    .data_i(q[0]));
  dpsem_dev_model i_dpsem_dev_model (.clk_i(clk_i), .sel_n_i({r_sel_n, c_sel}),
    .rw_n_i({r_rw_n, c_rw}), .oe_n_i({r_oe_n, c_oe}), .idx_i({r_idx, c_idx}),
    .d_i({{18{r_d0}}, c_d}), .q_o(q));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    rdat = dato;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic idle;
    do wb(1'h0, dpsem_pkg::STAT_OFS, 32'h0); while (rdat[0] !== 1'h0);
  endtask : idle
  function automatic logic [31:0] cw(input logic [1:0] op, input logic [2:0] i);
    return {24'h0, 1'h0, i, 2'h0, op};
  endfunction : cw
  task automatic cmd(input logic [1:0] op, input logic [2:0] i);
    wb(1'h1, dpsem_pkg::CMD_OFS, cw(op, i));
    idle();
  endtask : cmd
  // far side processor: select, then pulse, select dropped between accesses
  task automatic racc(input logic w, input logic [2:0] i, input logic b);
    @(posedge clk_i);
    {r_sel_n, r_idx, r_d0} <= {1'h0, i, b};
    @(posedge clk_i);
    {r_rw_n, r_oe_n} <= {!w, w};
    repeat (2) @(posedge clk_i);
    v = 32'(q[1]);
    {r_sel_n, r_rw_n, r_oe_n} <= 3'h7;
  endtask : racc
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    idle();
    for (int i = 0; i < 8; i++) begin
      racc(1'h0, 3'(i), 1'h0);
      chk(v, 32'h0);
      racc(1'h1, 3'(i), 1'h1);
    end
    wb(1'h0, dpsem_pkg::OWN_OFS, 32'h0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 8; i++) begin
      cmd(dpsem_pkg::OP_ACQUIRE, 3'(i));
      chk({rdat[25:8], rdat[1]}, 32'h1);
      racc(1'h0, 3'(i), 1'h0);
      chk(v, 32'h3FFFF);
    end
    wb(1'h0, dpsem_pkg::OWN_OFS, 32'h0);
    chk(rdat, 32'hFF);
    wb(1'h1, dpsem_pkg::CMD_OFS, 32'h102);
    idle();
    racc(1'h1, 3'h5, 1'h0);
    racc(1'h0, 3'h5, 1'h0);
    chk(v, 32'h0);
    racc(1'h1, 3'h5, 1'h1);
    $display("test ownership done");
    racc(1'h1, 3'h3, 1'h0);
    cmd(dpsem_pkg::OP_ACQUIRE, 3'h3);
    chk({rdat[25:8], rdat[1]}, 32'h7FFFE);
    racc(1'h1, 3'h3, 1'h1);
    cmd(dpsem_pkg::OP_POLL, 3'h3);
    chk({rdat[25:8], rdat[1]}, 32'h1);
    racc(1'h0, 3'h3, 1'h0);
    chk(v, 32'h3FFFF);
    cmd(dpsem_pkg::OP_RELEASE, 3'h3);
    racc(1'h0, 3'h3, 1'h0);
    chk(v, 32'h3FFFF);
    $display("test contention done");
    wb(1'h1, dpsem_pkg::CMD_OFS, cw(dpsem_pkg::OP_ACQUIRE, 3'h6));
    wb(1'h1, dpsem_pkg::CMD_OFS, cw(dpsem_pkg::OP_ACQUIRE, 3'h7));
    idle();
    wb(1'h0, dpsem_pkg::OWN_OFS, 32'h0);
    chk(rdat, 32'h40);
    wb(1'h0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
    $display("test busy done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
